//--- tb/vemx_pix_source.sv
// Purpose: Pixel source model driving both input ports of the register group
// Assumes: Pin clocks far slower than clk; each value held eight cycles around its edge
// Notes: Pin clocks stand still between pixels; data is inverted once the rising edge has passed
`timescale 1ns/100ps
module vemx_pix_source (
    input wire logic clk,
    output logic portAClk,
    output logic [23:0] inputPortA,
    output logic portBClk,
    output logic [23:0] inputPortB,
    output logic key2Detect
);
    initial begin
        portAClk = 1'b0;
        portBClk = 1'b0;
        inputPortA = 24'h000000;
        inputPortB = 24'h000000;
        key2Detect = 1'b0;
    end

    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One pixel: d is valid at the rising pin edge, ~d at the falling pin edge
    task automatic sendPix(input logic onB, input logic [23:0] d, input logic hit);
        waitCyc(1);
        key2Detect = hit;
        if (onB) inputPortB = d;
        else inputPortA = d;
        waitCyc(8);
        if (onB) portBClk = 1'b1;
        else portAClk = 1'b1;
        waitCyc(8);
        if (onB) inputPortB = ~d;
        else inputPortA = ~d;
        waitCyc(8);
        if (onB) portBClk = 1'b0;
        else portAClk = 1'b0;
        waitCyc(8);
        key2Detect = 1'b0;
    endtask
endmodule

//--- tb/vemx_regs_tb.sv
// Purpose: Self-checking bench for the key-2 table, path, edge, payload, phase and gain registers
// Assumes: Payload bit period shortened to two cycles
// Notes: Host writes keep bit 6 of the path byte at zero and bits 3 and 2 at one
`timescale 1ns/100ps
module vemx_regs_tb;
    localparam int BITCYC = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic [5:0] key2FadeFactor = 6'h00;
    logic line16Start = 1'b0;
    logic portAClk, portBClk, key2Detect, pixValid, progDataBit, progDataActive;
    logic [23:0] inputPortA, inputPortB, encoderPix, rgbPix;
    logic [7:0] regRdData, uChroma, vChroma, subcarrierPhase;
    logic [7:0] phases [4] = '{8'h0f, 8'h3a, 8'h35, 8'h57};
    logic [39:0] payload = 40'hf0_5a_c3_80_01;
    int failCount = 0;
    int cmpCount = 0;
    int cycles = 0;
    int validCnt = 0;

    vemx_regs #(.PROG_BIT_CYCLES(BITCYC)) u_dut (.clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .portAClk(portAClk),
        .inputPortA(inputPortA), .portBClk(portBClk), .inputPortB(inputPortB), .key2Detect(key2Detect),
        .key2FadeFactor(key2FadeFactor), .line16Start(line16Start), .encoderPix(encoderPix), .rgbPix(rgbPix),
        .pixValid(pixValid), .uChroma(uChroma), .vChroma(vChroma), .subcarrierPhase(subcarrierPhase),
        .progDataBit(progDataBit), .progDataActive(progDataActive));
    vemx_pix_source u_src (.clk(clk), .portAClk(portAClk), .inputPortA(inputPortA), .portBClk(portBClk),
        .inputPortB(inputPortB), .key2Detect(key2Detect));

    always #5 clk = ~clk;

    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Counts valid pulses and cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (pixValid === 1'b1) validCnt <= validCnt + 1;
        if (cycles == 6000) begin
            failCount++;
            giveVerdict();
        end
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmpCount++;
        if (got !== exp) begin
            failCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        tick(1);
        regWrEn = 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        tick(1);
        regRdEn = 1'b1;
        regAddr = a;
        tick(1);
        regRdEn = 1'b0;
        check({16'h0000, regRdData}, {16'h0000, e});
    endtask

    function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] l, input logic [5:0] f);
        int w;
        w = f + f[5];
        return 8'((w * a + (64 - w) * l) >> 6);
    endfunction

    function automatic logic [23:0] fader(input logic [23:0] a, input logic [23:0] l, input logic [5:0] f);
        return {blend(a[23:16], l[23:16], f), blend(a[15:8], l[15:8], f), blend(a[7:0], l[7:0], f)};
    endfunction

    function automatic logic [7:0] scale(input logic [7:0] c, input logic [8:0] g);
        int p;
        p = $signed(c ^ 8'h80) * $signed(g);
        return p[14:7];
    endfunction

    // One port B pixel; exactly one valid pulse, then both path outputs compared
    task automatic pixB(input logic [23:0] d, input logic hit, input logic [23:0] eEnc, input logic [23:0] eRgb);
        int n0;
        n0 = validCnt;
        u_src.sendPix(1'b1, d, hit);
        check(24'(validCnt - n0), 24'h000001);
        check(encoderPix, eEnc);
        check(rgbPix, eRgb);
    endtask

    task automatic pulse16();
        tick(1);
        line16Start = 1'b1;
        tick(1);
        line16Start = 1'b0;
    endtask

    initial begin
        tick(20);
        rst_n = 1'b1;
        for (int a = 'h51; a <= 'h5e; a++) begin
            rdChk(8'(a), (a <= 'h53) ? 8'h80 : (a == 'h54) ? 8'h0c : 8'h00);
        end
        wr(8'h50, 8'hff);
        wr(8'h5f, 8'hff);
        rdChk(8'h50, 8'h00);
        rdChk(8'h5f, 8'h00);
        for (int a = 'h51; a <= 'h5c; a++) begin
            wr(8'(a), (a == 'h54) ? 8'h3c : 8'(a) ^ 8'ha5);
            rdChk(8'(a), (a == 'h54) ? 8'h3c : 8'(a) ^ 8'ha5);
        end
        wr(8'h5d, 8'hff);
        rdChk(8'h5d, 8'h80);
        wr(8'h5e, 8'h7f);
        rdChk(8'h5e, 8'h00);
        foreach (phases[i]) begin
            wr(8'h5a, phases[i]);
            tick(2);
            check({16'h0000, subcarrierPhase}, {16'h0000, phases[i]});
        end
        // Table {Y,U,V} = 40,20,30; blue gain +125, red gain -256
        wr(8'h51, 8'h20);
        wr(8'h52, 8'h30);
        wr(8'h53, 8'h40);
        wr(8'h5b, 8'h7d);
        wr(8'h5d, 8'h00);
        wr(8'h5c, 8'h00);
        wr(8'h5e, 8'h80);
        wr(8'h54, 8'h0c);
        u_src.sendPix(1'b0, 24'ha0b0c0, 1'b0);
        pixB(24'hc0c0c0, 1'b1, 24'hc0c0c0, 24'hc0c0c0);
        check({16'h0000, uChroma}, {16'h0000, scale(8'hc0, 9'h07d)});
        check({16'h0000, vChroma}, {16'h0000, scale(8'hc0, 9'h100)});
        wr(8'h54, 8'h2c);
        foreach (phases[i]) begin
            key2FadeFactor = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'h20;
            pixB(24'h123456, 1'b1, fader(24'ha0b0c0, 24'h402030, key2FadeFactor), 24'h123456);
        end
        pixB(24'h654321, 1'b0, 24'h654321, 24'h654321);
        wr(8'h54, 8'h1c);
        key2FadeFactor = 6'h00;
        pixB(24'h777777, 1'b1, 24'h777777, 24'h402030);
        // Falling edges on both ports: each port takes the inverted value
        wr(8'h54, 8'h2f);
        key2FadeFactor = 6'h3f;
        u_src.sendPix(1'b0, 24'h112233, 1'b0);
        pixB(24'h0f0f0f, 1'b1, 24'heeddcc, 24'hf0f0f0);
        wr(8'h5b, 8'h00);
        wr(8'h5e, 8'h00);
        wr(8'h54, 8'h0c);
        pixB(24'h30e0f0, 1'b0, 24'h30e0f0, 24'h30e0f0);
        check({16'h0000, uChroma}, 24'h000000);
        check({16'h0000, vChroma}, 24'h000000);
        // Red gain at its nominal 100 IRE value
        wr(8'h5c, 8'haf);
        pixB(24'h30e0f0, 1'b0, 24'h30e0f0, 24'h30e0f0);
        check({16'h0000, vChroma}, {16'h0000, scale(8'hf0, 9'h0af)});
        check({16'h0000, uChroma}, 24'h000000);
        // Line-16 payload: ignored while disabled, then 40 bits LSB first from 55H upward
        for (int i = 0; i < 5; i++) begin
            wr(8'(8'h55 + i), payload[i * 8 +: 8]);
        end
        pulse16();
        tick(4);
        check({23'h000000, progDataActive}, 24'h000000);
        wr(8'h54, 8'h8c);
        regAddr = 8'h55;
        regWrData = 8'hfe;
        pulse16();
        for (int t = 0; t < 4 && progDataActive !== 1'b1; t++) begin
            tick(1);
        end
        for (int k = 0; k < 40 * BITCYC; k++) begin
            check({22'h000000, progDataActive, progDataBit}, {22'h000000, 1'b1, payload[k / BITCYC]});
            regWrEn = (k == 2);
            tick(1);
        end
        check({22'h000000, progDataActive, progDataBit}, 24'h000000);
        giveVerdict();
    end
endmodule

//--- verilog/vemx_pkg.sv
// Purpose: Shared constants for the mixer, programming-data and gain register group
// Assumes: Subaddress register port with 8-bit data
// Notes: Offsets are the subaddresses seen on the register port
package vemx_pkg;
    localparam logic [7:0] ADDR_LUT_U = 8'h51;
    localparam logic [7:0] ADDR_LUT_V = 8'h52;
    localparam logic [7:0] ADDR_LUT_Y = 8'h53;
    localparam logic [7:0] ADDR_PATH_CTRL = 8'h54;
    localparam logic [7:0] ADDR_PROG_B5 = 8'h55;
    localparam logic [7:0] ADDR_PROG_B11 = 8'h56;
    localparam logic [7:0] ADDR_PROG_B12 = 8'h57;
    localparam logic [7:0] ADDR_PROG_B13 = 8'h58;
    localparam logic [7:0] ADDR_PROG_B14 = 8'h59;
    localparam logic [7:0] ADDR_SC_PHASE = 8'h5a;
    localparam logic [7:0] ADDR_GAIN_U_LO = 8'h5b;
    localparam logic [7:0] ADDR_GAIN_V_LO = 8'h5c;
    localparam logic [7:0] ADDR_GAIN_U_HI = 8'h5d;
    localparam logic [7:0] ADDR_GAIN_V_HI = 8'h5e;

    localparam int BIT_INS_EN = 7;
    localparam int BIT_ENC_SRC = 5;
    localparam int BIT_RGB_SRC = 4;
    localparam int BIT_EDGE_B = 1;
    localparam int BIT_EDGE_A = 0;
    localparam int BIT_GAIN_MSB = 7;

    localparam logic [7:0] RST_LUT = 8'h80;
    localparam logic [7:0] RST_PATH_CTRL = 8'h0c;
    localparam logic [7:0] RST_OTHER = 8'h00;
    localparam logic [7:0] CHROMA_OFFSET = 8'h80;

    localparam int PROG_BYTES = 5;
    localparam int PROG_BITS = PROG_BYTES * 8;
    localparam int FADE_W = 6;
    // Bit period of the programming-data line payload, in ns
    localparam int PROG_BIT_NS = 200;
    localparam int CLK_NS = 10;
    localparam int PROG_BIT_CYC = (PROG_BIT_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        VEMX_IDLE = 2'b01,
        VEMX_SEND = 2'b10
    } vemx_prog_state_t;
endpackage

//--- verilog/vemx_port_sampler.sv
// Purpose: Samples a pixel port on the chosen edge of its pin clock
// Assumes: Pin clock far slower than clk; data stable around the chosen edge
// Notes: Three-stage synchronisers; a level change counts when stages two and three agree
`timescale 1ns/100ps
module vemx_port_sampler #(
    parameter int WIDTH = 24
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pinClk,
    input wire logic [WIDTH-1:0] pinData,
    input wire logic fallingEdge,
    output logic [WIDTH-1:0] sampleData,
    output logic sampleValid
);
    // Elaboration check on the port width
    if (WIDTH < 1) begin
        $error("WIDTH must be positive");
    end

    logic [2:0] clkSync_ff;
    logic [WIDTH-1:0] dat1_ff, dat2_ff, dat3_ff;
    logic level_ff, nxt_level;
    logic [WIDTH-1:0] sample_ff, nxt_sample;
    logic valid_ff, nxt_valid;
    logic rise, fall;

    always_comb begin
        nxt_level = level_ff;
        if (clkSync_ff[1] == clkSync_ff[2]) begin
            nxt_level = clkSync_ff[2];
        end
        rise = nxt_level & ~level_ff;
        fall = ~nxt_level & level_ff;
        nxt_valid = fallingEdge ? fall : rise;
        nxt_sample = nxt_valid ? dat3_ff : sample_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkSync_ff <= 3'h0;
            dat1_ff <= '0;
            dat2_ff <= '0;
            dat3_ff <= '0;
            level_ff <= 1'b0;
            sample_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            clkSync_ff <= {clkSync_ff[1:0], pinClk};
            dat1_ff <= pinData;
            dat2_ff <= dat1_ff;
            dat3_ff <= dat2_ff;
            level_ff <= nxt_level;
            sample_ff <= nxt_sample;
            valid_ff <= nxt_valid;
        end
    end

    assign sampleData = sample_ff;
    assign sampleValid = valid_ff;
endmodule

//--- verilog/vemx_regs.sv
// Purpose: Key-2 colour table, path select, sampling edge, programming data, phase and chroma gains
// Assumes: Subaddress register port already decoded from the serial control bus
// Notes: Port A carries video, port B the compressed-video pixels; both are {Y,U,V}
`timescale 1ns/100ps
// Function
// - Three key-2 table bytes, reset 80H, replace colour
// - Enable bit 7 inserts programming data line 16
// - Bit 5 picks encoder source: port B or fader
// - Bit 4 picks RGB source: port B or fader
// - Bits 1/0 pick falling or rising port edge
// - Five payload bytes 55H-59H, sent LSB first
// - Eight-bit subcarrier phase, 360/256 degree steps
// - Blue gain nine bits: 5BH low, 5DH MSB
// - Red gain nine bits: 5CH low, 5EH MSB
// - Zero blue gain removes U contribution
// - Zero red gain removes V contribution
// - Key 2 blends video and table by fade
// - Bit 7 of 5DH/5EH holds gain MSB
module vemx_regs #(
    parameter int PROG_BIT_CYCLES = vemx_pkg::PROG_BIT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic portAClk,
    input wire logic [23:0] inputPortA,
    input wire logic portBClk,
    input wire logic [23:0] inputPortB,
    input wire logic key2Detect,
    input wire logic [5:0] key2FadeFactor,
    input wire logic line16Start,
    output logic [23:0] encoderPix,
    output logic [23:0] rgbPix,
    output logic pixValid,
    output logic [7:0] uChroma,
    output logic [7:0] vChroma,
    output logic [7:0] subcarrierPhase,
    output logic progDataBit,
    output logic progDataActive
);
    // Elaboration check: the bit divider is eight bits wide
    if (PROG_BIT_CYCLES < 1 || PROG_BIT_CYCLES > 255) begin
        $error("PROG_BIT_CYCLES out of range");
    end

    // Register state
    logic [7:0] key2_lut_u_ff, key2_lut_v_ff, key2_lut_y_ff, pathCtrl_ff, phase_ff, gainULo_ff, gainVLo_ff;
    logic [7:0] nxt_key2_lut_u, nxt_key2_lut_v, nxt_key2_lut_y, nxt_pathCtrl, nxt_phase, nxt_gainULo, nxt_gainVLo;
    logic gainUHi_ff, gainVHi_ff, nxt_gainUHi, nxt_gainVHi;
    logic [7:0] progByte_ff [vemx_pkg::PROG_BYTES];
    logic [7:0] nxt_progByte [vemx_pkg::PROG_BYTES];
    logic [7:0] rdData_ff, nxt_rdData;
    logic [8:0] blueGain, redGain;

    always_comb begin
        nxt_key2_lut_u = key2_lut_u_ff;
        nxt_key2_lut_v = key2_lut_v_ff;
        nxt_key2_lut_y = key2_lut_y_ff;
        nxt_pathCtrl = pathCtrl_ff;
        nxt_phase = phase_ff;
        nxt_gainULo = gainULo_ff;
        nxt_gainVLo = gainVLo_ff;
        nxt_gainUHi = gainUHi_ff;
        nxt_gainVHi = gainVHi_ff;
        nxt_progByte = progByte_ff;
        if (regWrEn) begin
            case (regAddr)
                vemx_pkg::ADDR_LUT_U: nxt_key2_lut_u = regWrData;
                vemx_pkg::ADDR_LUT_V: nxt_key2_lut_v = regWrData;
                vemx_pkg::ADDR_LUT_Y: nxt_key2_lut_y = regWrData;
                vemx_pkg::ADDR_PATH_CTRL: nxt_pathCtrl = regWrData; // Stored as written
                vemx_pkg::ADDR_PROG_B5: nxt_progByte[0] = regWrData;
                vemx_pkg::ADDR_PROG_B11: nxt_progByte[1] = regWrData;
                vemx_pkg::ADDR_PROG_B12: nxt_progByte[2] = regWrData;
                vemx_pkg::ADDR_PROG_B13: nxt_progByte[3] = regWrData;
                vemx_pkg::ADDR_PROG_B14: nxt_progByte[4] = regWrData;
                vemx_pkg::ADDR_SC_PHASE: nxt_phase = regWrData;
                vemx_pkg::ADDR_GAIN_U_LO: nxt_gainULo = regWrData;
                vemx_pkg::ADDR_GAIN_V_LO: nxt_gainVLo = regWrData;
                vemx_pkg::ADDR_GAIN_U_HI: nxt_gainUHi = regWrData[vemx_pkg::BIT_GAIN_MSB];
                vemx_pkg::ADDR_GAIN_V_HI: nxt_gainVHi = regWrData[vemx_pkg::BIT_GAIN_MSB];
                default: ;
            endcase
        end
        nxt_rdData = rdData_ff;
        if (regRdEn) begin
            case (regAddr)
                vemx_pkg::ADDR_LUT_U: nxt_rdData = key2_lut_u_ff;
                vemx_pkg::ADDR_LUT_V: nxt_rdData = key2_lut_v_ff;
                vemx_pkg::ADDR_LUT_Y: nxt_rdData = key2_lut_y_ff;
                vemx_pkg::ADDR_PATH_CTRL: nxt_rdData = pathCtrl_ff;
                vemx_pkg::ADDR_PROG_B5: nxt_rdData = progByte_ff[0];
                vemx_pkg::ADDR_PROG_B11: nxt_rdData = progByte_ff[1];
                vemx_pkg::ADDR_PROG_B12: nxt_rdData = progByte_ff[2];
                vemx_pkg::ADDR_PROG_B13: nxt_rdData = progByte_ff[3];
                vemx_pkg::ADDR_PROG_B14: nxt_rdData = progByte_ff[4];
                vemx_pkg::ADDR_SC_PHASE: nxt_rdData = phase_ff;
                vemx_pkg::ADDR_GAIN_U_LO: nxt_rdData = gainULo_ff;
                vemx_pkg::ADDR_GAIN_V_LO: nxt_rdData = gainVLo_ff;
                vemx_pkg::ADDR_GAIN_U_HI: nxt_rdData = {gainUHi_ff, 7'h00};
                vemx_pkg::ADDR_GAIN_V_HI: nxt_rdData = {gainVHi_ff, 7'h00};
                default: nxt_rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key2_lut_u_ff <= vemx_pkg::RST_LUT;
            key2_lut_v_ff <= vemx_pkg::RST_LUT;
            key2_lut_y_ff <= vemx_pkg::RST_LUT;
            pathCtrl_ff <= vemx_pkg::RST_PATH_CTRL;
            phase_ff <= vemx_pkg::RST_OTHER;
            gainULo_ff <= vemx_pkg::RST_OTHER;
            gainVLo_ff <= vemx_pkg::RST_OTHER;
            gainUHi_ff <= 1'b0;
            gainVHi_ff <= 1'b0;
            for (int i = 0; i < vemx_pkg::PROG_BYTES; i++) begin
                progByte_ff[i] <= vemx_pkg::RST_OTHER;
            end
            rdData_ff <= 8'h00;
        end else begin
            key2_lut_u_ff <= nxt_key2_lut_u;
            key2_lut_v_ff <= nxt_key2_lut_v;
            key2_lut_y_ff <= nxt_key2_lut_y;
            pathCtrl_ff <= nxt_pathCtrl;
            phase_ff <= nxt_phase;
            gainULo_ff <= nxt_gainULo;
            gainVLo_ff <= nxt_gainVLo;
            gainUHi_ff <= nxt_gainUHi;
            gainVHi_ff <= nxt_gainVHi;
            progByte_ff <= nxt_progByte;
            rdData_ff <= nxt_rdData;
        end
    end

    assign blueGain = {gainUHi_ff, gainULo_ff};
    assign redGain = {gainVHi_ff, gainVLo_ff};

    // Input ports
    logic [23:0] portAData, portBData;
    logic portAValid, portBValid;

    vemx_port_sampler #(.WIDTH(24)) portASampler (
        .clk(clk),
        .rst_n(rst_n),
        .pinClk(portAClk),
        .pinData(inputPortA),
        .fallingEdge(pathCtrl_ff[vemx_pkg::BIT_EDGE_A]),
        .sampleData(portAData),
        .sampleValid(portAValid)
    );

    vemx_port_sampler #(.WIDTH(24)) portBSampler (
        .clk(clk),
        .rst_n(rst_n),
        .pinClk(portBClk),
        .pinData(inputPortB),
        .fallingEdge(pathCtrl_ff[vemx_pkg::BIT_EDGE_B]),
        .sampleData(portBData),
        .sampleValid(portBValid)
    );

    // Weight w runs 0..64 so a full-scale fade gives exactly the video pixel
    function automatic logic [7:0] vemx_blend(input logic [7:0] vid, input logic [7:0] lut,
                                              input logic [5:0] fade);
        logic [6:0] w;
        logic [15:0] acc;
        w = {1'b0, fade} + {6'h00, fade[5]};
        acc = 16'(w * vid) + 16'((7'h40 - w) * lut);
        return acc[13:6];
    endfunction

    // Pixel paths
    logic [23:0] faderPix, encPix_ff, nxt_encPix, rgbPix_ff, nxt_rgbPix;
    logic pixValid_ff, nxt_pixValid;
    logic [7:0] uChroma_ff, nxt_uChroma, vChroma_ff, nxt_vChroma;
    logic signed [16:0] uProd, vProd;

    always_comb begin
        faderPix = portBData;
        if (key2Detect) begin
            faderPix = {vemx_blend(portAData[23:16], key2_lut_y_ff, key2FadeFactor),
                        vemx_blend(portAData[15:8], key2_lut_u_ff, key2FadeFactor),
                        vemx_blend(portAData[7:0], key2_lut_v_ff, key2FadeFactor)};
        end
        nxt_pixValid = portBValid;
        nxt_encPix = encPix_ff;
        nxt_rgbPix = rgbPix_ff;
        nxt_uChroma = uChroma_ff;
        nxt_vChroma = vChroma_ff;
        uProd = $signed(portBData[15:8] ^ vemx_pkg::CHROMA_OFFSET) * $signed(blueGain);
        vProd = $signed(portBData[7:0] ^ vemx_pkg::CHROMA_OFFSET) * $signed(redGain);
        if (portBValid) begin
            nxt_encPix = pathCtrl_ff[vemx_pkg::BIT_ENC_SRC] ? faderPix : portBData;
            nxt_rgbPix = pathCtrl_ff[vemx_pkg::BIT_RGB_SRC] ? faderPix : portBData;
            nxt_uChroma = uProd[14:7]; // Zero gain gives zero product
            nxt_vChroma = vProd[14:7];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            encPix_ff <= 24'h000000;
            rgbPix_ff <= 24'h000000;
            pixValid_ff <= 1'b0;
            uChroma_ff <= 8'h00;
            vChroma_ff <= 8'h00;
        end else begin
            encPix_ff <= nxt_encPix;
            rgbPix_ff <= nxt_rgbPix;
            pixValid_ff <= nxt_pixValid;
            uChroma_ff <= nxt_uChroma;
            vChroma_ff <= nxt_vChroma;
        end
    end

    // Programming-data line payload
    vemx_pkg::vemx_prog_state_t progState_ff, nxt_progState;
    logic [vemx_pkg::PROG_BITS-1:0] shift_ff, nxt_shift;
    logic [5:0] bitCnt_ff, nxt_bitCnt;
    logic [7:0] div_ff, nxt_div;
    logic progBit_ff, nxt_progBit, progAct_ff, nxt_progAct;
    logic bitTick, progLoad;

    always_comb begin
        nxt_progState = progState_ff;
        nxt_shift = shift_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_div = div_ff;
        nxt_progBit = progBit_ff;
        nxt_progAct = progAct_ff;
        bitTick = (div_ff == 8'(PROG_BIT_CYCLES - 1));
        progLoad = 1'b0;
        case (progState_ff)
            vemx_pkg::VEMX_IDLE: begin
                if (line16Start && pathCtrl_ff[vemx_pkg::BIT_INS_EN]) begin
                    progLoad = 1'b1;
                    // Snapshot so mid-line writes cannot tear the packet
                    nxt_shift = {progByte_ff[4], progByte_ff[3], progByte_ff[2],
                                 progByte_ff[1], progByte_ff[0]};
                    nxt_progBit = progByte_ff[0][0];
                    nxt_progAct = 1'b1;
                    nxt_bitCnt = 6'h00;
                    nxt_div = 8'h00;
                    nxt_progState = vemx_pkg::VEMX_SEND;
                end
            end
            vemx_pkg::VEMX_SEND: begin
                nxt_div = bitTick ? 8'h00 : div_ff + 8'h01;
                if (bitTick) begin
                    if (bitCnt_ff == 6'(vemx_pkg::PROG_BITS - 1)) begin
                        nxt_progAct = 1'b0;
                        nxt_progBit = 1'b0;
                        nxt_progState = vemx_pkg::VEMX_IDLE;
                    end else begin
                        nxt_shift = {1'b0, shift_ff[vemx_pkg::PROG_BITS-1:1]};
                        nxt_progBit = shift_ff[1];
                        nxt_bitCnt = bitCnt_ff + 6'h01;
                    end
                end
            end
            default: begin
                nxt_progState = vemx_pkg::VEMX_IDLE;
                nxt_progAct = 1'b0;
                nxt_progBit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            progState_ff <= vemx_pkg::VEMX_IDLE;
            shift_ff <= '0;
            bitCnt_ff <= 6'h00;
            div_ff <= 8'h00;
            progBit_ff <= 1'b0;
            progAct_ff <= 1'b0;
        end else begin
            progState_ff <= nxt_progState;
            shift_ff <= nxt_shift;
            bitCnt_ff <= nxt_bitCnt;
            div_ff <= nxt_div;
            progBit_ff <= nxt_progBit;
            progAct_ff <= nxt_progAct;
        end
    end

    assign regRdData = rdData_ff;
    assign encoderPix = encPix_ff;
    assign rgbPix = rgbPix_ff;
    assign pixValid = pixValid_ff;
    assign uChroma = uChroma_ff;
    assign vChroma = vChroma_ff;
    assign subcarrierPhase = phase_ff;
    assign progDataBit = progBit_ff;
    assign progDataActive = progAct_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_lut_write: assert property (regWrEn && regAddr == vemx_pkg::ADDR_LUT_Y
        |=> key2_lut_y_ff == $past(regWrData)) else $error("table byte not written");
    chk_ins_disabled: assert property (line16Start && !pathCtrl_ff[vemx_pkg::BIT_INS_EN]
        && progState_ff == vemx_pkg::VEMX_IDLE |=> !progAct_ff) else $error("insertion while disabled");
    chk_enc_bypass: assert property (portBValid && !pathCtrl_ff[vemx_pkg::BIT_ENC_SRC]
        |=> encPix_ff == $past(portBData)) else $error("encoder bypass wrong");
    chk_rgb_fader: assert property (portBValid && pathCtrl_ff[vemx_pkg::BIT_RGB_SRC] && key2Detect
        && key2FadeFactor == 6'h00 |=> rgbPix_ff == {key2_lut_y_ff, key2_lut_u_ff, key2_lut_v_ff}) else $error("rgb fader wrong");
    chk_first_bit: assert property (progLoad |=> progBit_ff == $past(progByte_ff[0][0])
        ##1 progAct_ff) else $error("payload not LSB first");
    chk_payload_hold: assert property (progLoad |=> progAct_ff [*8]) else $error("payload ended early");
    chk_gain_msb: assert property (regWrEn && regAddr == vemx_pkg::ADDR_GAIN_V_HI
        |=> redGain[8] == $past(regWrData[7])) else $error("red gain msb wrong");
    chk_zero_u: assert property (portBValid && blueGain == 9'h000 |=> uChroma_ff == 8'h00)
        else $error("U not removed");
    chk_zero_v: assert property (portBValid && redGain == 9'h000 |=> vChroma_ff == 8'h00)
        else $error("V not removed");
    chk_phase_out: assert property (regWrEn && regAddr == vemx_pkg::ADDR_SC_PHASE
        |=> subcarrierPhase == $past(regWrData)) else $error("phase not applied");

    cov_payload: cover property (progLoad ##1 progAct_ff [*8]);
    cov_fader_enc: cover property (portBValid && key2Detect && pathCtrl_ff[vemx_pkg::BIT_ENC_SRC]);
    cov_falling_a: cover property (portAValid && pathCtrl_ff[vemx_pkg::BIT_EDGE_A]);
endmodule
